// ==== mtc_pkg.sv ====
// package of constants for the five-channel timer unit
// assumes a 32-bit classic wishbone register bus and synchronous pin inputs
package mtc_pkg;

  // geometry
  localparam int unsigned MTC_NCH     = 5;
  localparam int unsigned MTC_CW      = 16;
  localparam int unsigned MTC_NOTOG_CH = 2;
  localparam logic [15:0] MTC_CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] MTC_CNT_ZERO = 16'h0000;

  // global register byte offsets (page 0)
  localparam logic [7:0] MTC_OFS_START = 8'h00;
  localparam logic [7:0] MTC_OFS_SYNC  = 8'h04;
  localparam logic [7:0] MTC_OFS_PWM   = 8'h08;

  // channel n lives in page n+1, page is address bits 7:5
  localparam logic [2:0] MTC_PAGE_GLB = 3'h0;
  localparam logic [2:0] MTC_PAGE_CH0 = 3'h1;
  localparam logic [4:0] MTC_CH_CTRL  = 5'h00;
  localparam logic [4:0] MTC_CH_IOC   = 5'h04;
  localparam logic [4:0] MTC_CH_IEN   = 5'h08;
  localparam logic [4:0] MTC_CH_FLAG  = 5'h0C;
  localparam logic [4:0] MTC_CH_CNT   = 5'h10;
  localparam logic [4:0] MTC_CH_GRA   = 5'h14;
  localparam logic [4:0] MTC_CH_GRB   = 5'h18;

  // channel_control_reg fields
  localparam int unsigned MTC_CS_LSB = 0;
  localparam int unsigned MTC_ES_LSB = 3;
  localparam int unsigned MTC_CC_LSB = 5;

  // io_control_reg fields
  localparam int unsigned MTC_IOA_LSB = 0;
  localparam int unsigned MTC_IOB_LSB = 4;

  // timer_flag_reg / enable bit positions
  localparam int unsigned MTC_FLG_A  = 0;
  localparam int unsigned MTC_FLG_B  = 1;
  localparam int unsigned MTC_FLG_OV = 2;

  // clock select codes
  localparam logic [2:0] MTC_CS_DIV1 = 3'h0;
  localparam logic [2:0] MTC_CS_DIV2 = 3'h1;
  localparam logic [2:0] MTC_CS_DIV4 = 3'h2;
  localparam logic [2:0] MTC_CS_DIV8 = 3'h3;

  // edge codes, shared by clock edge select and capture edge select
  localparam logic [1:0] MTC_EDGE_RISE = 2'h0;
  localparam logic [1:0] MTC_EDGE_FALL = 2'h1;

  // io action codes; bit 2 set selects input capture
  localparam logic [2:0] MTC_IO_NONE = 3'h0;
  localparam logic [2:0] MTC_IO_LOW  = 3'h1;
  localparam logic [2:0] MTC_IO_HIGH = 3'h2;
  localparam logic [2:0] MTC_IO_TOG  = 3'h3;
  localparam int unsigned MTC_IO_CAP = 2;

  // clear source codes
  localparam logic [1:0] MTC_CLR_NONE = 2'h0;
  localparam logic [1:0] MTC_CLR_A    = 2'h1;
  localparam logic [1:0] MTC_CLR_B    = 2'h2;
  localparam logic [1:0] MTC_CLR_SYNC = 2'h3;

  // reset values
  localparam logic [6:0]  MTC_RST_CTRL = 7'h00;
  localparam logic [6:0]  MTC_RST_IOC  = 7'h00;
  localparam logic [15:0] MTC_RST_GR   = 16'hFFFF;
  localparam logic [31:0] MTC_RD_ZERO  = 32'h0000_0000;

endpackage

// ==== mtc_edge_det.sv ====
// edge detector with selectable rising, falling or both-edge pulse
// assumes the level input is already synchronous to the clock
`timescale 1ns/1ps
module mtc_edge_det
  import mtc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       level,
  input  wire logic [1:0] edge_sel,
  output logic            pulse
);

  typedef struct packed {
    logic prev;
  } mtc_edge_t;

  mtc_edge_t s_q;
  mtc_edge_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.prev = level;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  always_comb begin
    if (edge_sel == MTC_EDGE_RISE) begin
      pulse = ce & level & ~s_q.prev;
    end else if (edge_sel == MTC_EDGE_FALL) begin
      pulse = ce & ~level & s_q.prev;
    end else begin
      pulse = ce & (level ^ s_q.prev);
    end
  end

endmodule // mtc_edge_det

// ==== mtc_timer_unit.sv ====
// five-channel 16-bit timer: compare, capture, sync preset/clear, pwm
// assumes a classic wishbone master and pins synchronous to CORE_CLK
//
// Notes on behaviour
// [R1] internal counter clock is system clock divided by 1, 2, 4 or 8
// [R2] external clock from one of four pins, counting rising, falling or both edges
// [R3] external clock pulses last at least 1.5 clocks, 2.5 for both edges
// [R4] compare match drives pin low, high or toggle; channel 2 cannot toggle
// [R5] a fixed level already on the pin leaves the pin unchanged
// [R6] match fires on the counter clock that leaves the matching value
// [R7] on match the selected io action is applied to that channel pin
// [R8] capture edge on a pin copies the counter into its general register
// [R9] capture selected as clear source clears the counter on capture
// [R10] capture pulses last at least 1.5 clocks, 2.5 for both edges
// [R11] counter write on a synced channel presets all synced channels together
// [R12] synced channels on sync clear clear when another synced channel clears
// [R13] per-channel sync bit puts any of channels 0 to 4 in the group
// [R14] setting a channel start bit makes that counter count
// [R15] clear source: none, match/capture A, match/capture B, or synchronous
// [R16] pwm mode: pin A goes high at match A, low at match B
// [R17] pwm forces both registers to compare; pin B keeps its own action
// [R18] pwm with equal general registers never changes the pwm output
// [R19] clearing on B with A above B stays low; reverse stays high
// [R20] pwm mode is selectable per channel through the mode register
// [R21] wrap from all ones to zero sets overflow flag and requests if enabled
// [R22] match sets its flag, clears if configured, requests if enabled
// [R23] counter advances by one per qualified clock while started, else holds
`timescale 1ns/1ps
module mtc_timer_unit
  import mtc_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        CORE_CE,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic [3:0]  EXT_CLOCK_PIN_I,
  input  wire logic [4:0]  CHANNEL_PIN_A_I,
  output logic      [4:0]  CHANNEL_PIN_A_O,
  output logic      [4:0]  CHANNEL_PIN_A_OE,
  input  wire logic [4:0]  CHANNEL_PIN_B_I,
  output logic      [4:0]  CHANNEL_PIN_B_O,
  output logic      [4:0]  CHANNEL_PIN_B_OE,
  output logic      [4:0]  IRQ_REQ_O
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic                  ack;
    logic [31:0]           dat;
    logic [2:0]            presc;
    logic [MTC_NCH-1:0]    start;
    logic [MTC_NCH-1:0]    sync;
    logic [MTC_NCH-1:0]    pwm;
    logic [MTC_NCH-1:0][6:0]  ctrl;
    logic [MTC_NCH-1:0][6:0]  ioc;
    logic [MTC_NCH-1:0][2:0]  ien;
    logic [MTC_NCH-1:0][2:0]  flag;
    logic [MTC_NCH-1:0][15:0] cnt;
    logic [MTC_NCH-1:0][15:0] general_reg_a;
    logic [MTC_NCH-1:0][15:0] general_reg_b;
    logic [MTC_NCH-1:0]    pa;
    logic [MTC_NCH-1:0]    pb;
  } mtc_state_t;

  mtc_state_t s_q;
  mtc_state_t s_d;

  logic [MTC_NCH-1:0] ext_lvl;
  logic [MTC_NCH-1:0] ext_pulse;
  logic [MTC_NCH-1:0] cap_pulse_a;
  logic [MTC_NCH-1:0] cap_pulse_b;
  logic [MTC_NCH-1:0] tick;
  logic [MTC_NCH-1:0] mat_a;
  logic [MTC_NCH-1:0] mat_b;
  logic [MTC_NCH-1:0] cap_a;
  logic [MTC_NCH-1:0] cap_b;
  logic [MTC_NCH-1:0] own_clr;
  logic               sync_clr;
  logic               hit;
  logic               wr;
  logic [2:0]         page;
  logic [4:0]         ofs;
  logic [2:0]         ch;
  logic               is_glb;
  logic               is_ch;
  logic [31:0]        rdat;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(logic [15:0] old, logic [31:0] wd,
                                          logic [3:0] sel);
    merge16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
  endfunction

  // level a compare pin takes on a match
  function automatic logic pin_act(logic [2:0] io, logic cur, logic tog_ok);
    case (io)
      MTC_IO_LOW:  pin_act = 1'b0;                          // [R4] [R5]
      MTC_IO_HIGH: pin_act = 1'b1;                          // [R4] [R5]
      MTC_IO_TOG:  pin_act = tog_ok ? ~cur : 1'b1;          // [R4]
      default:     pin_act = cur;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // edge detectors for external clocks and capture pins

  for (genvar g = 0; g < MTC_NCH; g++) begin : g_edge
    assign ext_lvl[g] = EXT_CLOCK_PIN_I[s_q.ctrl[g][MTC_CS_LSB +: 2]]; // [R2]

    mtc_edge_det u_clk_edge (
      .clk      (CORE_CLK),
      .rst_n    (RST_N),
      .ce       (CORE_CE),
      .level    (ext_lvl[g]),
      .edge_sel (s_q.ctrl[g][MTC_ES_LSB +: 2]),
      .pulse    (ext_pulse[g])
    );

    mtc_edge_det u_cap_a_edge (
      .clk      (CORE_CLK),
      .rst_n    (RST_N),
      .ce       (CORE_CE),
      .level    (CHANNEL_PIN_A_I[g]),
      .edge_sel (s_q.ioc[g][MTC_IOA_LSB +: 2]),
      .pulse    (cap_pulse_a[g])
    );

    mtc_edge_det u_cap_b_edge (
      .clk      (CORE_CLK),
      .rst_n    (RST_N),
      .ce       (CORE_CE),
      .level    (CHANNEL_PIN_B_I[g]),
      .edge_sel (s_q.ioc[g][MTC_IOB_LSB +: 2]),
      .pulse    (cap_pulse_b[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode and read mux

  always_comb begin
    hit    = WB_CYC_I & WB_STB_I;
    page   = WB_ADR_I[7:5];
    ofs    = WB_ADR_I[4:0];
    ch     = 3'(page - MTC_PAGE_CH0);
    is_glb = (page == MTC_PAGE_GLB);
    is_ch  = (page != MTC_PAGE_GLB) && (32'(ch) < MTC_NCH);
    // writes land on the edge at which the master samples ack
    wr     = hit & WB_WE_I & s_q.ack;
    rdat   = MTC_RD_ZERO;
    if (is_glb) begin
      if ({page, ofs} == MTC_OFS_START) begin
        rdat = 32'(s_q.start);
      end else if ({page, ofs} == MTC_OFS_SYNC) begin
        rdat = 32'(s_q.sync);
      end else if ({page, ofs} == MTC_OFS_PWM) begin
        rdat = 32'(s_q.pwm);
      end
    end else if (is_ch) begin
      if (ofs == MTC_CH_CTRL) begin
        rdat = 32'(s_q.ctrl[ch]);
      end else if (ofs == MTC_CH_IOC) begin
        rdat = 32'(s_q.ioc[ch]);
      end else if (ofs == MTC_CH_IEN) begin
        rdat = 32'(s_q.ien[ch]);
      end else if (ofs == MTC_CH_FLAG) begin
        rdat = 32'(s_q.flag[ch]);
      end else if (ofs == MTC_CH_CNT) begin
        rdat = 32'(s_q.cnt[ch]);
      end else if (ofs == MTC_CH_GRA) begin
        rdat = 32'(s_q.general_reg_a[ch]);
      end else if (ofs == MTC_CH_GRB) begin
        rdat = 32'(s_q.general_reg_b[ch]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel events

  always_comb begin
    logic [2:0] cs;
    logic [2:0] ioa;
    logic [2:0] iob;
    logic [1:0] cc;
    logic       int_tick;
    cs       = 3'h0;
    ioa      = 3'h0;
    iob      = 3'h0;
    cc       = 2'h0;
    int_tick = 1'b0;
    sync_clr = 1'b0;
    for (int i = 0; i < MTC_NCH; i++) begin
      cs  = s_q.ctrl[i][MTC_CS_LSB +: 3];
      cc  = s_q.ctrl[i][MTC_CC_LSB +: 2];
      ioa = s_q.ioc[i][MTC_IOA_LSB +: 3];
      iob = s_q.ioc[i][MTC_IOB_LSB +: 3];
      case (cs)
        MTC_CS_DIV1: int_tick = 1'b1;                       // [R1]
        MTC_CS_DIV2: int_tick = s_q.presc[0];               // [R1]
        MTC_CS_DIV4: int_tick = &s_q.presc[1:0];            // [R1]
        MTC_CS_DIV8: int_tick = &s_q.presc;                 // [R1]
        default:     int_tick = 1'b0;
      endcase
      // count only while started, on internal or external clock
      tick[i] = s_q.start[i] & (cs[2] ? ext_pulse[i] : int_tick); // [R14] [R23] [R2]
      // match on the tick that leaves the matching value; pwm forces compare
      mat_a[i] = tick[i] & (s_q.pwm[i] | ~ioa[MTC_IO_CAP])
                 & (s_q.cnt[i] == s_q.general_reg_a[i]);              // [R6] [R17]
      mat_b[i] = tick[i] & (s_q.pwm[i] | ~iob[MTC_IO_CAP])
                 & (s_q.cnt[i] == s_q.general_reg_b[i]);              // [R6] [R17]
      cap_a[i] = ~s_q.pwm[i] & ioa[MTC_IO_CAP] & cap_pulse_a[i]; // [R8] [R17]
      cap_b[i] = ~s_q.pwm[i] & iob[MTC_IO_CAP] & cap_pulse_b[i]; // [R8] [R17]
      own_clr[i] = ((cc == MTC_CLR_A) & (mat_a[i] | cap_a[i]))
                 | ((cc == MTC_CLR_B) & (mat_b[i] | cap_b[i])); // [R9] [R15] [R22]
      if (s_q.sync[i] & own_clr[i]) begin
        sync_clr = 1'b1;                                    // [R12]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [2:0]  ioa;
    logic [2:0]  iob;
    logic [1:0]  cc;
    logic        pre_hit;
    logic [15:0] pre_val;
    logic        tog_ok;
    s_d     = s_q;
    ioa     = 3'h0;
    iob     = 3'h0;
    cc      = 2'h0;
    pre_hit = wr & is_ch & (ofs == MTC_CH_CNT);
    pre_val = merge16(s_q.cnt[ch], WB_DAT_I, WB_SEL_I);
    tog_ok  = 1'b0;

    // bus slave: ack one cycle after the strobe, dropped the cycle after
    s_d.ack   = hit & ~s_q.ack;
    s_d.dat   = (hit & ~s_q.ack) ? rdat : s_q.dat;
    s_d.presc = s_q.presc + 3'h1;                           // [R1]

    if (wr & is_glb & WB_SEL_I[0]) begin
      if ({page, ofs} == MTC_OFS_START) begin
        s_d.start = WB_DAT_I[MTC_NCH-1:0];                  // [R14]
      end else if ({page, ofs} == MTC_OFS_SYNC) begin
        s_d.sync = WB_DAT_I[MTC_NCH-1:0];                   // [R13]
      end else if ({page, ofs} == MTC_OFS_PWM) begin
        s_d.pwm = WB_DAT_I[MTC_NCH-1:0];                    // [R20]
      end
    end

    for (int i = 0; i < MTC_NCH; i++) begin
      cc     = s_q.ctrl[i][MTC_CC_LSB +: 2];
      ioa    = s_q.ioc[i][MTC_IOA_LSB +: 3];
      iob    = s_q.ioc[i][MTC_IOB_LSB +: 3];
      tog_ok = (i != MTC_NOTOG_CH);

      // configuration writes
      if (wr & is_ch & (ch == 3'(i)) & WB_SEL_I[0]) begin
        if (ofs == MTC_CH_CTRL) begin
          s_d.ctrl[i] = WB_DAT_I[6:0];
        end else if (ofs == MTC_CH_IOC) begin
          s_d.ioc[i] = WB_DAT_I[6:0];
        end else if (ofs == MTC_CH_IEN) begin
          s_d.ien[i] = WB_DAT_I[2:0];
        end
      end

      // general registers: capture wins over a bus write
      if (cap_a[i]) begin
        s_d.general_reg_a[i] = s_q.cnt[i];                            // [R8]
      end else if (wr & is_ch & (ch == 3'(i)) & (ofs == MTC_CH_GRA)) begin
        s_d.general_reg_a[i] = merge16(s_q.general_reg_a[i], WB_DAT_I, WB_SEL_I);
      end
      if (cap_b[i]) begin
        s_d.general_reg_b[i] = s_q.cnt[i];                            // [R8]
      end else if (wr & is_ch & (ch == 3'(i)) & (ofs == MTC_CH_GRB)) begin
        s_d.general_reg_b[i] = merge16(s_q.general_reg_b[i], WB_DAT_I, WB_SEL_I);
      end

      // counter: preset, clear, count
      if (pre_hit & ((ch == 3'(i)) | (s_q.sync[ch] & s_q.sync[i]))) begin
        s_d.cnt[i] = pre_val;                               // [R11] [R13]
      end else if (own_clr[i]) begin
        s_d.cnt[i] = MTC_CNT_ZERO;                          // [R9] [R15] [R22]
      end else if ((cc == MTC_CLR_SYNC) & s_q.sync[i] & sync_clr) begin
        s_d.cnt[i] = MTC_CNT_ZERO;                          // [R12] [R15]
      end else if (tick[i]) begin
        s_d.cnt[i] = s_q.cnt[i] + 16'h0001;                 // [R23] [R21]
      end

      // flags: written zeros clear, a set in the same cycle wins
      if (wr & is_ch & (ch == 3'(i)) & (ofs == MTC_CH_FLAG) & WB_SEL_I[0]) begin
        s_d.flag[i] = s_q.flag[i] & WB_DAT_I[2:0];
      end
      if (mat_a[i] | cap_a[i]) begin
        s_d.flag[i][MTC_FLG_A] = 1'b1;                      // [R22]
      end
      if (mat_b[i] | cap_b[i]) begin
        s_d.flag[i][MTC_FLG_B] = 1'b1;                      // [R22]
      end
      if (tick[i] & (s_q.cnt[i] == MTC_CNT_MAX) & ~own_clr[i]) begin
        s_d.flag[i][MTC_FLG_OV] = 1'b1;                     // [R21]
      end

      // pin A: pwm waveform or compare action
      if (s_q.pwm[i]) begin
        if (s_q.general_reg_a[i] != s_q.general_reg_b[i]) begin                 // [R18]
          if (mat_a[i]) begin
            s_d.pa[i] = 1'b1;                               // [R16] [R19]
          end else if (mat_b[i]) begin
            s_d.pa[i] = 1'b0;                               // [R16] [R19]
          end
        end
      end else if (mat_a[i] & ~ioa[MTC_IO_CAP]) begin
        s_d.pa[i] = pin_act(ioa, s_q.pa[i], tog_ok);        // [R7] [R4]
      end

      // pin B keeps its own action in pwm mode too
      if (mat_b[i] & ~iob[MTC_IO_CAP]) begin
        s_d.pb[i] = pin_act(iob, s_q.pb[i], tog_ok);        // [R7] [R17]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q       <= '0;
      s_q.ctrl  <= {MTC_NCH{MTC_RST_CTRL}};
      s_q.ioc   <= {MTC_NCH{MTC_RST_IOC}};
      s_q.general_reg_a   <= {MTC_NCH{MTC_RST_GR}};
      s_q.general_reg_b   <= {MTC_NCH{MTC_RST_GR}};
    end else if (CORE_CE) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    logic [2:0] ioa;
    logic [2:0] iob;
    ioa = 3'h0;
    iob = 3'h0;
    for (int i = 0; i < MTC_NCH; i++) begin
      ioa = s_q.ioc[i][MTC_IOA_LSB +: 3];
      iob = s_q.ioc[i][MTC_IOB_LSB +: 3];
      CHANNEL_PIN_A_OE[i] = s_q.pwm[i] | (~ioa[MTC_IO_CAP] & (ioa != MTC_IO_NONE));
      CHANNEL_PIN_B_OE[i] = ~iob[MTC_IO_CAP] & (iob != MTC_IO_NONE); // [R17]
      IRQ_REQ_O[i]        = |(s_q.flag[i] & s_q.ien[i]);    // [R21] [R22]
    end
  end

  assign CHANNEL_PIN_A_O = s_q.pa;
  assign CHANNEL_PIN_B_O = s_q.pb;
  assign WB_DAT_O        = s_q.dat;
  assign WB_ACK_O        = s_q.ack;

endmodule // mtc_timer_unit

// ==== mtc_timer_props.sv ====
// port checker for the five-channel timer unit
// assumes it is bound onto mtc_timer_unit; one clock domain
`timescale 1ns/1ps
module mtc_timer_props
  import mtc_pkg::*;
(
  input logic        CORE_CLK,
  input logic        RST_N,
  input logic        CORE_CE,
  input logic        WB_CYC_I,
  input logic        WB_STB_I,
  input logic        WB_WE_I,
  input logic [31:0] WB_DAT_O,
  input logic        WB_ACK_O,
  input logic [4:0]  CHANNEL_PIN_A_O,
  input logic [4:0]  CHANNEL_PIN_A_OE,
  input logic [4:0]  CHANNEL_PIN_B_O,
  input logic [4:0]  CHANNEL_PIN_B_OE,
  input logic [4:0]  IRQ_REQ_O
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  chk_ack_latency: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && CORE_CE |=> WB_ACK_O)
    else $error("ack not one cycle after request");
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  chk_rdata_hold: assert property (!$stable(WB_DAT_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("read data changed between accesses");
  chk_a_oe_write: assert property (
    !$stable(CHANNEL_PIN_A_OE) |-> $past(WB_ACK_O && WB_WE_I))
    else $error("pin a enable changed without write");
  chk_b_oe_write: assert property (
    !$stable(CHANNEL_PIN_B_OE) |-> $past(WB_ACK_O && WB_WE_I))
    else $error("pin b enable changed without write");
  chk_irq_fall: assert property (
    |($past(IRQ_REQ_O) & ~IRQ_REQ_O) |-> $past(WB_ACK_O && WB_WE_I))
    else $error("request dropped without write");
  chk_ce_freeze: assert property ($past(!CORE_CE) |-> $stable(CHANNEL_PIN_A_O) &&
    $stable(CHANNEL_PIN_B_O) && $stable(IRQ_REQ_O))
    else $error("state moved while clock enable low");
endmodule // mtc_timer_props

bind mtc_timer_unit mtc_timer_props mtc_timer_props_inst (.CORE_CLK, .RST_N, .CORE_CE,
  .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_DAT_O, .WB_ACK_O, .CHANNEL_PIN_A_O,
  .CHANNEL_PIN_A_OE, .CHANNEL_PIN_B_O, .CHANNEL_PIN_B_OE, .IRQ_REQ_O);

// ==== mtc_pulse_src.sv ====
// external pulse source for timer clock pins and capture pins
// assumes pins idle low through pull-downs
`timescale 1ns/1ps
module mtc_pulse_src (
  input  logic       clk,
  output logic [3:0] ext_clk,
  output logic [4:0] cap_b
);
  initial begin
    ext_clk = 4'h0;
    cap_b = 5'h00;
  end
  // each level held 3 clocks, above the both-edge minimum width
  task automatic pulse(input logic [3:0] ck, input logic [4:0] cb, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      ext_clk <= ck;
      cap_b <= cb;
      repeat (3) @(posedge clk);
      ext_clk <= 4'h0;
      cap_b <= 5'h00;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule // mtc_pulse_src

// ==== tb_mtc_timer_unit.sv ====
// self-checking bench for the five-channel timer unit
// assumes mtc_pulse_src drives the clock and capture pins
`timescale 1ns/1ps
module tb_mtc_timer_unit
  import mtc_pkg::*;
;
  logic        clk, rst_n, ce, cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel, ext;
  logic [31:0] dat_i, dat_o;
  logic [4:0]  pa_o, pa_oe, pb_o, pb_oe, irq, pa_i, pb_i, capb;
  logic [15:0] rd;
  int          mismatches, n_tests, cycles;
  // pins nobody drives read low through the pull-downs
  assign pa_i = pa_oe & pa_o;
  assign pb_i = (pb_oe & pb_o) | (~pb_oe & capb);
  mtc_timer_unit mtc_timer_unit_inst (.CORE_CLK(clk), .RST_N(rst_n), .CORE_CE(ce),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .EXT_CLOCK_PIN_I(ext),
    .CHANNEL_PIN_A_I(pa_i), .CHANNEL_PIN_A_O(pa_o), .CHANNEL_PIN_A_OE(pa_oe),
    .CHANNEL_PIN_B_I(pb_i), .CHANNEL_PIN_B_O(pb_o), .CHANNEL_PIN_B_OE(pb_oe),
    .IRQ_REQ_O(irq));
  mtc_pulse_src mtc_pulse_src_inst (.clk(clk), .ext_clk(ext), .cap_b(capb));
  ////////////////////////////////////////
  function automatic logic [7:0] ca(input int c, input logic [4:0] o);
    return {3'(c + 1), o};
  endfunction
  function automatic logic [15:0] ctl(input logic [2:0] cs, input logic [1:0] es,
                                      input logic [1:0] cc);
    return {9'h000, cc, es, cs};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= {16'h0000, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    acc(1'b0, a, 16'h0000);
    chk(rd, exp);
  endtask
  task automatic pls(input logic [3:0] ck, input logic [4:0] cb, input int n);
    mtc_pulse_src_inst.pulse(ck, cb, n);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    chk(16'(pa_oe | pb_oe | irq), 16'h0000);
    rdc(ca(0, MTC_CH_GRA), MTC_RST_GR);
    rdc(ca(4, MTC_CH_GRB), MTC_RST_GR);
    rdc(ca(2, MTC_CH_CTRL), 16'h0000);
    wr(8'hE0, 16'h5A5A);
    rdc(8'hE0, 16'h0000);
  endtask
  task automatic t_presc();
    logic [15:0] h;
    for (int k = 0; k < 4; k++) begin
      wr(ca(0, MTC_CH_CTRL), ctl(3'(k), MTC_EDGE_RISE, MTC_CLR_NONE));
      wr(ca(0, MTC_CH_CNT), 16'h0000);
      wr(MTC_OFS_START, 16'h0001);
      repeat (64) @(posedge clk);
      wr(MTC_OFS_START, 16'h0000);
      acc(1'b0, ca(0, MTC_CH_CNT), 16'h0000);
      h = rd;
      chk(16'(int'(h) + 1 >= (67 >> k) && int'(h) <= (67 >> k) + 1), 16'h0001);
      repeat (8) @(posedge clk);
      rdc(ca(0, MTC_CH_CNT), h);
    end
  endtask
  task automatic t_ext();
    logic [1:0] es;
    for (int p = 0; p < 4; p++) begin
      es = (p == 1) ? MTC_EDGE_FALL : (p == 2) ? 2'h2 : MTC_EDGE_RISE;
      wr(ca(1, MTC_CH_CTRL), ctl({1'b1, 2'(p)}, es, MTC_CLR_NONE));
      wr(ca(1, MTC_CH_CNT), 16'h0000);
      wr(MTC_OFS_START, 16'h0002);
      pls(4'(1 << p), 5'h00, 4);
      rdc(ca(1, MTC_CH_CNT), es[1] ? 16'h0008 : 16'h0004);
    end
  endtask
  task automatic t_cmp();
    for (int c = 1; c < 3; c++) begin
      wr(ca(c, MTC_CH_CTRL), ctl(3'h4, MTC_EDGE_RISE, MTC_CLR_A));
      wr(ca(c, MTC_CH_IOC), {9'h000, MTC_IO_HIGH, 1'b0, MTC_IO_TOG});
      wr(ca(c, MTC_CH_GRA), 16'h0003);
      wr(ca(c, MTC_CH_GRB), 16'h0001);
      wr(ca(c, MTC_CH_CNT), 16'h0000);
      wr(ca(c, MTC_CH_FLAG), 16'h0000);
    end
    wr(MTC_OFS_START, 16'h0006);
    pls(4'h1, 5'h00, 3);
    chk(16'({pb_o[2:1], pa_o[2:1]}), 16'h000C);
    pls(4'h1, 5'h00, 1);
    chk(16'({pa_oe[2:1], pa_o[2:1]}), 16'h000F);
    rdc(ca(1, MTC_CH_CNT), 16'h0000);
    rdc(ca(1, MTC_CH_FLAG), 16'h0003);
    pls(4'h1, 5'h00, 4);
    chk(16'({pb_o[2:1], pa_o[2:1]}), 16'h000E);
  endtask
  task automatic t_cap();
    wr(ca(3, MTC_CH_CTRL), ctl(3'h4, MTC_EDGE_RISE, MTC_CLR_B));
    wr(ca(3, MTC_CH_IOC), {9'h000, 1'b1, MTC_EDGE_RISE, 4'h0});
    wr(ca(3, MTC_CH_CNT), 16'h0000);
    wr(MTC_OFS_START, 16'h0008);
    pls(4'h1, 5'h00, 5);
    pls(4'h0, 5'h08, 1);
    rdc(ca(3, MTC_CH_GRB), 16'h0005);
    rdc(ca(3, MTC_CH_CNT), 16'h0000);
  endtask
  task automatic t_sync();
    wr(ca(0, MTC_CH_CNT), 16'h0000);
    wr(MTC_OFS_SYNC, 16'h0012);
    wr(ca(1, MTC_CH_IOC), 16'h0000);
    wr(ca(1, MTC_CH_GRA), 16'h1236);
    wr(ca(4, MTC_CH_CTRL), ctl(3'h4, MTC_EDGE_RISE, MTC_CLR_SYNC));
    wr(ca(1, MTC_CH_CNT), 16'h1234);
    rdc(ca(4, MTC_CH_CNT), 16'h1234);
    rdc(ca(0, MTC_CH_CNT), 16'h0000);
    wr(MTC_OFS_START, 16'h0012);
    pls(4'h1, 5'h00, 2);
    rdc(ca(4, MTC_CH_CNT), 16'h1236);
    pls(4'h1, 5'h00, 1);
    rdc(ca(4, MTC_CH_CNT), 16'h0000);
    wr(MTC_OFS_SYNC, 16'h0000);
  endtask
  task automatic t_pwm();
    logic [1:0]  cc [5] = '{MTC_CLR_B, MTC_CLR_B, MTC_CLR_B, MTC_CLR_A, MTC_CLR_B};
    logic [15:0] ga [5] = '{16'h0002, 16'h0002, 16'h0003, 16'h0002, 16'h0006};
    logic [15:0] gb [5] = '{16'h0004, 16'h0004, 16'h0003, 16'h0005, 16'h0004};
    int          np [5] = '{3, 5, 10, 10, 10};
    logic [4:0]  pv = 5'b01001;
    wr(MTC_OFS_PWM, 16'h0001);
    wr(ca(0, MTC_CH_IOC), 16'h0000);
    chk(16'({pa_oe[1:0], pb_oe[0]}), 16'h0002);
    wr(MTC_OFS_START, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      wr(ca(0, MTC_CH_CTRL), ctl(3'h5, MTC_EDGE_RISE, cc[i]));
      wr(ca(0, MTC_CH_GRA), ga[i]);
      wr(ca(0, MTC_CH_GRB), gb[i]);
      wr(ca(0, MTC_CH_CNT), 16'h0000);
      pls(4'h2, 5'h00, np[i]);
      chk(16'(pa_o[0]), 16'(pv[i]));
    end
    wr(MTC_OFS_PWM, 16'h0000);
  endtask
  task automatic t_ovf();
    wr(ca(0, MTC_CH_CTRL), ctl(MTC_CS_DIV8, MTC_EDGE_RISE, MTC_CLR_NONE));
    wr(ca(0, MTC_CH_GRA), 16'h8000);
    wr(ca(0, MTC_CH_GRB), 16'h8000);
    wr(ca(0, MTC_CH_IEN), 16'h0004);
    wr(ca(0, MTC_CH_FLAG), 16'h0000);
    wr(ca(0, MTC_CH_CNT), 16'hFFFE);
    wr(MTC_OFS_START, 16'h0001);
    repeat (40) @(posedge clk);
    ce <= 1'b0;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    wr(MTC_OFS_START, 16'h0000);
    chk(16'(irq[0]), 16'h0001);
    rdc(ca(0, MTC_CH_FLAG), 16'h0004);
    acc(1'b0, ca(0, MTC_CH_CNT), 16'h0000);
    chk(16'(rd < 16'h0010 && rd > 16'h0000), 16'h0001);
    wr(ca(0, MTC_CH_FLAG), 16'h0003);
    chk(16'(irq[0]), 16'h0000);
  endtask
  ////////////////////////////////////////
  task automatic print_verdict();
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h3;
    dat_i = 32'h0000_0000;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_presc();
    t_ext();
    t_cmp();
    t_cap();
    t_sync();
    t_pwm();
    t_ovf();
    print_verdict();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      print_verdict();
    end
  end
endmodule // tb_mtc_timer_unit
